/* File: src/mcs_clock_guard.sv */
// mcs_clock_guard: clock system with oscillator guard and AXI4-Lite regs
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module mcs_clock_guard #(
  parameter int START_CYC = mcs_pkg::START_CYC,  // main settle cycles
  parameter int POR_CYC   = mcs_pkg::POR_OSC_CYC // power-on osc cycles
) (
  input  wire logic        clock_i,          // 100 MHz system clock
  input  wire logic        rst_b_i,          // async reset, active low
  input  wire logic [11:0] s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // byte enables
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write answer
  output logic             s_axi_bvalid,     // write answer valid
  input  wire logic        s_axi_bready,     // write answer ready
  input  wire logic [11:0] s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read answer
  output logic             s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready,     // read data ready
  input  wire logic        main_osc_i,       // main oscillator level
  input  wire logic        guard_option_enable_i, // guard option
  input  wire logic        osc_type_option_i,     // oscillator type option
  input  wire logic        instr_start_i,    // cpu starts an instruction
  input  wire logic [1:0]  instr_len_i,      // 0:2, 1:4, else 5 cycles
  output logic             main_osc_en_o,    // main oscillator enable
  output logic             resistor_osc_o,   // resistor oscillator mode
  output logic             on_aux_o,         // running from backup osc
  output logic             por_done_o,       // power-on delay expired
  output logic [7:0]      conv_ctrl_o,      // converter control bits
  output mcs_pkg::mcs_ticks_t ticks_o,       // clock enables
  output logic             instr_busy_o,     // instruction executing
  output logic             instr_done_o      // instruction finished
);
  localparam int AUX_N = int'(mcs_pkg::AUX_CYC); // backup period, cycles

  logic        guard;                        // guard option in force
  logic        stop_eff;                     // stop request in force
  logic        osc_prev_q;                   // last main level
  logic        raw_edge, acc_edge;           // main edges seen, kept
  logic [7:0]  miss_q, miss_d;               // cycles since main edge
  logic [7:0]  spc_q, spc_d;                 // cycles since kept edge
  logic [11:0] start_q, start_d;             // main settle counter
  logic [11:0] por_q, por_d;                 // power-on osc counter
  logic        main_alive, main_ready;       // main oscillating, settled
  logic        main_en_q, main_en_d;         // main enable
  mcs_pkg::mcs_src_t src_q, src_d;           // clock source state
  logic [7:0]  tmr_q, tmr_d;                 // aux phase / gap timer
  logic        aux_tick;                     // backup oscillator edge
  logic        osc_tick;                     // selected oscillator edge
  logic [1:0]  dcnt_q, dcnt_d;               // divider phase
  logic [1:0]  ratio_q, ratio_d;             // ratio code in use
  logic [1:0]  dlast;                        // last phase of ratio
  logic        int_tick_q, int_tick_d;       // internal clock enable
  logic        periph_tick, cpu_tick;        // divided tick enables
  logic [2:0]  mc_q, mc_d;                   // machine cycles left
  logic        done_q, done_d;               // instruction done pulse
  logic [7:0]  conv_q, conv_d;               // converter control reg
  logic [3:0]  div_q, div_d;                 // divider control reg
  logic        aw_q, aw_d, w_q, w_d;         // write halves held
  logic [11:0] awa_q, awa_d;                 // held write address
  logic [7:0]  wd_q, wd_d;                   // held write data
  logic        ws_q, ws_d;                   // held low byte enable
  logic        bv_q, bv_d, rv_q, rv_d;       // answers pending
  logic [1:0]  br_q, br_d, rr_q, rr_d;       // answer codes
  logic [31:0] rd_q, rd_d;                   // read data
  mcs_pkg::mcs_stat_t stat;                  // status word

  // guard is a fixed option, never a register bit
  assign guard    = guard_option_enable_i;
  // only the stop bit matters here; the rest goes to the converter
  assign stop_eff = guard & conv_q[mcs_pkg::OSC_STOP_BIT];
  // a stopped main oscillator produces no edges
  assign raw_edge = main_en_q & main_osc_i & ~osc_prev_q;
  // edges closer than the limit spacing are spikes and are dropped
  assign acc_edge = raw_edge & (~guard |
                    (spc_q >= mcs_pkg::GUARD_MIN_CYC));
  assign main_alive = miss_q < mcs_pkg::MISS_CYC;
  assign main_ready = main_alive & (start_q == 12'(START_CYC));
  // user code sees the same ticks from either source, only slower
  assign osc_tick = (src_q == mcs_pkg::SRC_MAIN & acc_edge) |
                    (src_q == mcs_pkg::SRC_AUX & aux_tick);

  // oscillator monitor: miss, spacing, settle and power-on counts
  always_comb begin
    miss_d  = raw_edge ? 8'h00 :
              (main_alive ? miss_q + 8'h01 : miss_q);
    spc_d   = acc_edge ? 8'h00 :
              (spc_q == 8'hFF ? spc_q : spc_q + 8'h01);
    start_d = !main_alive ? 12'h000 :
              (main_ready ? start_q : start_q + 12'h001);
    // power-on delay counts whichever source clocks the chip
    por_d   = (osc_tick && por_q != 12'(POR_CYC)) ?
              por_q + 12'h001 : por_q;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_prev_q <= 1'b0;
      miss_q     <= mcs_pkg::MISS_CYC;
      spc_q      <= 8'hFF;
      start_q    <= 12'h000;
      por_q      <= 12'h000;
    end else begin
      osc_prev_q <= main_osc_i;
      miss_q     <= miss_d;
      spc_q      <= spc_d;
      start_q    <= start_d;
      por_q      <= por_d;
    end
  end

  // main enable: off at once on stop, back on at instruction end
  always_comb begin
    main_en_d = main_en_q;
    if (stop_eff) begin
      main_en_d = 1'b0;
    end else if (!main_en_q && mc_q == 3'h0) begin
      main_en_d = 1'b1;
    end
  end

  // source switch; gaps hold the clock low so no short pulse leaks
  always_comb begin
    src_d    = src_q;
    tmr_d    = tmr_q;
    aux_tick = 1'b0;
    case (src_q)
      mcs_pkg::SRC_MAIN: begin
        if (guard && !main_alive) begin
          src_d = mcs_pkg::SRC_TO_AUX;
          tmr_d = 8'h00;
        end
      end
      mcs_pkg::SRC_TO_AUX: begin
        // wait one backup period with no clock at all
        if (tmr_q == mcs_pkg::AUX_CYC - 8'h01) begin
          src_d = mcs_pkg::SRC_AUX;
          tmr_d = 8'h00;
        end else begin
          tmr_d = tmr_q + 8'h01;
        end
      end
      mcs_pkg::SRC_AUX: begin
        if (tmr_q == mcs_pkg::AUX_CYC - 8'h01) begin
          aux_tick = 1'b1;
          tmr_d    = 8'h00;
        end else begin
          tmr_d = tmr_q + 8'h01;
        end
        if (main_ready && main_en_q) begin
          src_d = mcs_pkg::SRC_TO_MAIN;
        end
      end
      mcs_pkg::SRC_TO_MAIN: begin
        // resume on a clean main edge; that edge itself is not used
        if (acc_edge) begin
          src_d = mcs_pkg::SRC_MAIN;
        end else if (!main_alive) begin
          src_d = mcs_pkg::SRC_AUX;
          tmr_d = 8'h00;
        end
      end
      default: begin
        src_d = mcs_pkg::SRC_AUX;
      end
    endcase
    if (!guard) begin
      src_d = mcs_pkg::SRC_MAIN;
    end
  end

  // reset starts on the backup source so it can run the power-on delay
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_en_q <= 1'b1;
      src_q     <= mcs_pkg::SRC_AUX;
      tmr_q     <= 8'h00;
    end else begin
      main_en_q <= main_en_d;
      src_q     <= src_d;
      tmr_q     <= tmr_d;
    end
  end

  // ratio divider; a new ratio is only taken at the period boundary
  always_comb begin
    case (ratio_q)
      2'b00:   dlast = 2'h0;
      2'b01:   dlast = 2'h1;
      default: dlast = 2'h3;
    endcase
    dcnt_d     = dcnt_q;
    ratio_d    = ratio_q;
    int_tick_d = 1'b0;
    if (osc_tick) begin
      if (dcnt_q == dlast) begin
        dcnt_d     = 2'h0;
        int_tick_d = 1'b1;
        ratio_d    = div_q[mcs_pkg::DIV_SEL_LSB +: 2];
      end else begin
        dcnt_d = dcnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dcnt_q     <= 2'h0;
      ratio_q    <= mcs_pkg::DIV_RST[mcs_pkg::DIV_SEL_LSB +: 2];
      int_tick_q <= 1'b0;
    end else begin
      dcnt_q     <= dcnt_d;
      ratio_q    <= ratio_d;
      int_tick_q <= int_tick_d;
    end
  end

  // peripheral clock and machine cycle from the internal clock
  mcs_tick_div #(.N(mcs_pkg::PERIPH_DIV)) u_periph_div (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_i  (int_tick_q),
    .tick_o  (periph_tick)
  );
  mcs_tick_div #(.N(mcs_pkg::CPU_DIV)) u_cpu_div (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_i  (int_tick_q),
    .tick_o  (cpu_tick)
  );
  // the carrier is driven as one word, never field by field
  assign ticks_o = '{int_tick: int_tick_q, periph_tick: periph_tick,
                     cpu_tick: cpu_tick};

  // instruction length in machine cycles
  always_comb begin
    mc_d   = mc_q;
    done_d = 1'b0;
    if (mc_q == 3'h0) begin
      if (instr_start_i) begin
        case (instr_len_i)
          2'b00:   mc_d = 3'h2;
          2'b01:   mc_d = 3'h4;
          default: mc_d = 3'h5;
        endcase
      end
    end else if (ticks_o.cpu_tick) begin
      mc_d   = mc_q - 3'h1;
      done_d = (mc_q == 3'h1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mc_q   <= 3'h0;
      done_q <= 1'b0;
    end else begin
      mc_q   <= mc_d;
      done_q <= done_d;
    end
  end

  // bus slave: address and data in either order, answer after both
  assign stat = '{ratio: ratio_q, por_done: (por_q == 12'(POR_CYC)),
                  main_en: main_en_q,
                  on_aux: (src_q != mcs_pkg::SRC_MAIN)};
  always_comb begin
    aw_d = aw_q;  w_d = w_q;  awa_d = awa_q;  wd_d = wd_q;
    ws_d = ws_q;  bv_d = bv_q;  br_d = br_q;
    rv_d = rv_q;  rr_d = rr_q;  rd_d = rd_q;
    conv_d = conv_q;  div_d = div_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata[7:0];
      ws_d = s_axi_wstrb[0];
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = mcs_pkg::RESP_OKAY;
      case (awa_q)
        mcs_pkg::ADDR_CONV: if (ws_q) conv_d = wd_q;
        // upper nibble unused; reserved bits are stored as written
        mcs_pkg::ADDR_DIV:  if (ws_q) div_d = wd_q[3:0];
        mcs_pkg::ADDR_STAT: ;
        default: br_d = mcs_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = mcs_pkg::RESP_OKAY;
      rd_d = 32'h0000_0000;
      case (s_axi_araddr)
        mcs_pkg::ADDR_CONV: rd_d = {24'h00_0000, conv_q};
        // write-only: the divider reads back as zero
        mcs_pkg::ADDR_DIV:  rd_d = 32'h0000_0000;
        mcs_pkg::ADDR_STAT: rd_d = {27'h000_0000, stat};
        default: rr_d = mcs_pkg::RESP_SLVERR;
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_q <= 1'b0;  w_q <= 1'b0;  awa_q <= 12'h000;
      wd_q <= 8'h00;  ws_q <= 1'b0;  bv_q <= 1'b0;
      br_q <= mcs_pkg::RESP_OKAY;  rv_q <= 1'b0;
      rr_q <= mcs_pkg::RESP_OKAY;  rd_q <= 32'h0000_0000;
      conv_q <= mcs_pkg::CONV_RST;
      div_q  <= mcs_pkg::DIV_RST;
    end else begin
      aw_q <= aw_d;  w_q <= w_d;  awa_q <= awa_d;
      wd_q <= wd_d;  ws_q <= ws_d;  bv_q <= bv_d;
      br_q <= br_d;  rv_q <= rv_d;  rr_q <= rr_d;  rd_q <= rd_d;
      conv_q <= conv_d;
      div_q  <= div_d;
    end
  end

  assign s_axi_awready  = ~aw_q & ~bv_q;
  assign s_axi_wready   = ~w_q & ~bv_q;
  assign s_axi_bvalid   = bv_q;
  assign s_axi_bresp    = br_q;
  assign s_axi_arready  = ~rv_q;
  assign s_axi_rvalid   = rv_q;
  assign s_axi_rresp    = rr_q;
  assign s_axi_rdata    = rd_q;
  assign main_osc_en_o  = main_en_q;
  assign resistor_osc_o = osc_type_option_i;
  assign on_aux_o       = stat.on_aux;
  assign por_done_o     = stat.por_done;
  assign conv_ctrl_o    = conv_q;
  assign instr_busy_o   = (mc_q != 3'h0);
  assign instr_done_o   = done_q;

  property p_stop_off;
    @(posedge clock_i) disable iff (!rst_b_i)
    stop_eff |=> !main_en_q;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("main enable stayed on under stop");

  property p_no_guard;
    @(posedge clock_i) disable iff (!rst_b_i)
    !guard |=> src_q == mcs_pkg::SRC_MAIN;
  endproperty
  a_no_guard: assert property (p_no_guard)
    else $error("backup source used without guard");

  property p_aux_start;
    @(posedge clock_i) disable iff (!rst_b_i)
    (guard && $rose(src_q == mcs_pkg::SRC_TO_AUX)) |->
      ##[1:AUX_N] src_q == mcs_pkg::SRC_AUX;
  endproperty
  a_aux_start: assert property (p_aux_start)
    else $error("backup source late after missing edge");

  property p_gap_quiet;
    @(posedge clock_i) disable iff (!rst_b_i)
    (src_q == mcs_pkg::SRC_TO_AUX || src_q == mcs_pkg::SRC_TO_MAIN)
      |=> !int_tick_q;
  endproperty
  a_gap_quiet: assert property (p_gap_quiet)
    else $error("clock edge during source switch");

  property p_spacing;
    @(posedge clock_i) disable iff (!rst_b_i)
    (guard && acc_edge) |=> !acc_edge [*8];
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("guard kept an edge too soon");

  property p_ratio;
    @(posedge clock_i) disable iff (!rst_b_i)
    (osc_tick && dcnt_q == dlast) |=>
      ratio_q == $past(div_q[1:0]) && int_tick_q;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("ratio not taken at boundary");

  property p_cpu_div;
    @(posedge clock_i) disable iff (!rst_b_i)
    ticks_o.cpu_tick |-> $past(int_tick_q) && !$past(ticks_o.cpu_tick);
  endproperty
  a_cpu_div: assert property (p_cpu_div)
    else $error("machine cycle tick without internal tick");

  property p_instr;
    @(posedge clock_i) disable iff (!rst_b_i)
    (instr_start_i && mc_q == 3'h0 && instr_len_i == 2'b00) |=>
      mc_q == 3'h2;
  endproperty
  a_instr: assert property (p_instr)
    else $error("two-cycle instruction not loaded");

  property p_aux_off;
    @(posedge clock_i) disable iff (!rst_b_i)
    (guard && src_q == mcs_pkg::SRC_AUX && main_ready && main_en_q)
      |=> src_q == mcs_pkg::SRC_TO_MAIN;
  endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("backup source kept after main runs");
endmodule

/* File: src/mcs_pkg.sv */
// mcs_pkg: constants, states and carriers of the clock system with guard
package mcs_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 10;
  // backup slow oscillator period
  localparam int AUX_PERIOD_NS = 1000;
  localparam logic [7:0] AUX_CYC = 8'(AUX_PERIOD_NS / CLK_PERIOD_NS);
  // least spacing of main edges at guard_limit_freq (rounded up)
  localparam int GUARD_MIN_NS = 125;
  localparam logic [7:0] GUARD_MIN_CYC =
    8'((GUARD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // no main edge for this long counts as a missing edge
  localparam int MISS_NS = 500;
  localparam logic [7:0] MISS_CYC = 8'(MISS_NS / CLK_PERIOD_NS);
  // main oscillator start-up settle time
  localparam int START_NS = 10000;
  localparam int START_CYC = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-on delay in oscillator cycles
  localparam int POR_OSC_CYC = 2048;
  // peripheral and machine-cycle division
  localparam int PERIPH_DIV = 12;
  localparam int CPU_DIV = 13;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CONV = 8'hD1;
  localparam logic [7:0] IDX_DIV = 8'hDC;
  localparam logic [7:0] IDX_STAT = 8'hE0;
  localparam logic [11:0] ADDR_CONV = {2'h0, IDX_CONV, 2'h0};
  localparam logic [11:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
  // fields and reset values
  localparam int OSC_STOP_BIT = 2;
  localparam int DIV_SEL_LSB = 0;
  localparam int DIV_RSV_MSB = 3;
  localparam logic [7:0] CONV_RST = 8'h00;
  localparam logic [3:0] DIV_RST = 4'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // clock source selection
  typedef enum logic [1:0] {
    SRC_MAIN    = 2'b00,
    SRC_TO_AUX  = 2'b01,
    SRC_AUX     = 2'b10,
    SRC_TO_MAIN = 2'b11
  } mcs_src_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic int_tick;
    logic periph_tick;
    logic cpu_tick;
  } mcs_ticks_t;

  // status word, low bits of the status register
  typedef struct packed {
    logic [1:0] ratio;
    logic       por_done;
    logic       main_en;
    logic       on_aux;
  } mcs_stat_t;
endpackage

/* File: src/mcs_tick_div.sv */
// mcs_tick_div: divides a tick stream by N, registered output tick
`timescale 1ns/1ps
module mcs_tick_div #(
  parameter int N = 12                  // division ratio
) (
  input  wire logic clock_i,            // system clock
  input  wire logic rst_b_i,            // async reset, active low
  input  wire logic tick_i,             // input tick
  output logic      tick_o              // one pulse per N input ticks
);
  localparam int W = $clog2(N);
  logic [W-1:0] cnt_q, cnt_d;           // ticks seen in this period
  logic         tick_d;                 // next output tick

  // count input ticks and pulse on the last one
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (tick_i) begin
      if (cnt_q == W'(N - 1)) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule

/* File: verif/tb_mcs_clock_guard.sv */
// tb_mcs_clock_guard: self-checking bench of the guarded clock system
`timescale 1ns/1ps
module tb_mcs_clock_guard;
  logic        clock_i = 1'h0;
  logic        rst_b_i = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, main_osc_i = 1'h0;
  logic        guard_option_enable_i = 1'h1, osc_type_option_i = 1'h0;
  logic        instr_start_i = 1'h0;
  logic [1:0]  instr_len_i = 2'h0, s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, main_osc_en_o;
  logic        resistor_osc_o, on_aux_o, por_done_o;
  logic        instr_busy_o, instr_done_o;
  logic [7:0]  conv_ctrl_o;
  mcs_pkg::mcs_ticks_t ticks_o;
  int          n_mismatch = 0, comparisons = 0, cyc = 0;
  int          osc_half = 10, oc = 0, g;  // main half period, 0 stops it
  logic [7:0]  div_shadow = 8'h00;  // software copy of the divider

  always #5 clock_i = ~clock_i;

  // short settle and power-on counts keep the run brief
  mcs_clock_guard #(.START_CYC(10), .POR_CYC(8)) i_dut (
    .clock_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .main_osc_i, .guard_option_enable_i, .osc_type_option_i,
    .instr_start_i, .instr_len_i, .main_osc_en_o, .resistor_osc_o,
    .on_aux_o, .por_done_o, .conv_ctrl_o, .ticks_o, .instr_busy_o,
    .instr_done_o);

  // main oscillator stand-in; a stopped one freezes at its last level
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (osc_half > 0 && oc >= osc_half - 1) begin
      oc <= 0;
      main_osc_i <= ~main_osc_i;
    end else if (osc_half > 0) begin
      oc <= oc + 1;
    end
    if (cyc == 40000) begin  // hang guard, far above the expected run
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one write; address and data released each as it is taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge clock_i);
      if (!ad && s_axi_awready) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge clock_i);
    chk(s_axi_bresp, mcs_pkg::RESP_OKAY, "bresp");
    s_axi_bready <= 1'h0;
    @(posedge clock_i);  // lets the next request start on a fresh edge
  endtask

  task automatic axi_rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clock_i); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock_i); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clock_i);
  endtask

  // cycles between two later pulses of tick bit b (2 int, 1 periph, 0 cpu)
  task automatic gap(input int b);
    repeat (2) begin
      do @(posedge clock_i); while (!ticks_o[b]);
      g = 0;
      do begin
        @(posedge clock_i);
        g++;
      end while (!ticks_o[b]);
    end
  endtask

  task automatic wait_aux(input logic v);
    int w;
    w = 0;
    while (on_aux_o !== v && w < 400) begin
      @(posedge clock_i);
      w++;
    end
    chk(on_aux_o, v, "backup source state");
  endtask

  // reset held 16 cycles while the guard strap takes the value gd
  task automatic t_reset(input logic gd);
    rst_b_i <= 1'h0;
    guard_option_enable_i <= gd;
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'h1;
    @(posedge clock_i);
    chk(main_osc_en_o, 1'h1, "main enabled after reset");
    chk(conv_ctrl_o, 8'h00, "conv reset");
    wait_aux(1'h0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    repeat (300) @(posedge clock_i);
    chk(por_done_o, 1'h1, "power-on delay done");
    axi_rd(mcs_pkg::ADDR_STAT);
    chk(rd[2:0], 3'h6, "status por main aux");
    axi_rd(mcs_pkg::ADDR_DIV);
    chk(rd, 32'h0, "divider reads zero");
    axi_rd(12'h000);
    chk(rd, 32'h0, "unmapped read data");
    chk(rsp, mcs_pkg::RESP_SLVERR, "unmapped read answer");
    // a write with the low byte masked must leave the register alone
    s_axi_wstrb <= 4'h0;
    axi_wr(mcs_pkg::ADDR_CONV, 8'hFF);
    s_axi_wstrb <= 4'hF;
    chk(conv_ctrl_o, 8'h00, "masked write ignored");
    $display("test regs done");
  endtask

  task automatic t_ratio();
    int r[4] = '{1, 2, 4, 4};
    for (int c = 0; c < 4; c++) begin
      div_shadow = 8'(c);
      axi_wr(mcs_pkg::ADDR_DIV, div_shadow);
      gap(2);
      chk(g, 20 * r[c], "internal tick spacing");
      axi_rd(mcs_pkg::ADDR_STAT);
      chk(rd[4:3], div_shadow[1:0], "ratio code in use");
    end
    div_shadow = 8'h00;
    axi_wr(mcs_pkg::ADDR_DIV, div_shadow);
    gap(1);
    chk(g, 240, "peripheral tick spacing");
    gap(0);
    chk(g, 260, "machine cycle spacing");
    $display("test ratio done");
  endtask

  task automatic t_instr();
    int e[3] = '{2, 4, 5};
    int n;
    for (int k = 0; k < 3; k++) begin
      instr_len_i <= 2'(k);
      instr_start_i <= 1'h1;
      @(posedge clock_i);
      instr_start_i <= 1'h0;
      n = 0;
      do begin
        @(posedge clock_i);
        n += int'(ticks_o.cpu_tick);
        if (instr_done_o !== 1'h1)
          chk(instr_busy_o, 1'h1, "busy while running");
      end while (instr_done_o !== 1'h1);
      chk(n, e[k], "machine cycles per instruction");
      chk(instr_busy_o, 1'h0, "idle after done");
      @(posedge clock_i);
    end
    $display("test instr done");
  endtask

  task automatic t_stop();
    axi_wr(mcs_pkg::ADDR_CONV, 8'h04);
    chk(main_osc_en_o, 1'h0, "stop bit stops main");
    chk(conv_ctrl_o, 8'h04, "conv value");
    wait_aux(1'h1);
    axi_wr(mcs_pkg::ADDR_CONV, 8'h00);
    chk(main_osc_en_o, 1'h1, "main restarted");
    wait_aux(1'h0);
    osc_half = 0;  // failed oscillator, no more edges
    wait_aux(1'h1);
    osc_half = 10;
    wait_aux(1'h0);
    osc_type_option_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    chk(resistor_osc_o, 1'h1, "resistor mode");
    osc_half = 3;  // edges every 6 cycles, faster than the limit allows
    gap(2);
    chk(g >= 13, 1'h1, "spikes dropped");
    osc_half = 10;
    axi_wr(mcs_pkg::ADDR_CONV, 8'h04);
    chk(main_osc_en_o, 1'h0, "stopped before reset");
    // reset under stop restarts main; guard stays off for exact timing
    t_reset(1'h0);
    axi_wr(mcs_pkg::ADDR_CONV, 8'h04);
    chk(main_osc_en_o, 1'h1, "stop ignored without guard");
    repeat (100) @(posedge clock_i);
    chk(on_aux_o, 1'h0, "no backup without guard");
    $display("test stop done");
  endtask

  initial begin
    t_reset(1'h1);
    t_regs();
    t_stop();
    t_ratio();
    t_instr();
    print_verdict();
  end
endmodule
